// File: hw/clk_rst_pkg.sv
/*
  Shared constants and carrier types for the clock, reset and bootstrap control block.
  Assumes a single 100 MHz system clock and a plain address/strobe register port.
*/
package clk_rst_pkg;

  localparam logic [31:0] pll_rate_control_addr   = 32'hffb0_0008;
  localparam logic [31:0] sw_service_addr         = 32'hffb0_000c;
  localparam logic [31:0] pll_settings_addr       = 32'hffb0_0040;
  localparam logic [31:0] boot_status_addr        = 32'hffb0_0044;

  localparam int          rate_sel_lsb            = 24;
  localparam int          rate_sel_msb            = 27;
  localparam logic [3:0]  rate_sel_reset          = 4'h9;
  localparam logic [4:0]  rate_sel_mult_offset    = 5'h04;

  localparam logic [3:0]  cp_low_last             = 4'h2;
  localparam logic [3:0]  cp_mid_last             = 4'ha;
  localparam logic [1:0]  cp_low                  = 2'h1;
  localparam logic [1:0]  cp_mid                  = 2'h2;
  localparam logic [1:0]  cp_high                 = 2'h3;

  localparam logic [11:0] sw_key_first            = 12'h123;
  localparam logic [11:0] sw_key_second           = 12'h321;

  localparam logic [4:0]  sw_reset_cycles         = 5'h10;
  localparam logic [4:0]  rate_reset_cycles       = 5'h10;

  localparam int          strap_endian_bit        = 27;
  localparam int          strap_cpu_boot_bit      = 26;
  localparam int          strap_cs_lsb            = 23;
  localparam int          strap_id_lsb            = 9;
  localparam int          strap_cp_lsb            = 7;
  localparam int          strap_div_lsb           = 5;
  localparam int          strap_mult_lsb          = 0;

  typedef struct packed {
    logic [1:0] charge_pump_current;
    logic [1:0] pll_output_divider;
    logic [4:0] pll_multiplier;
  } pll_settings_t;

  typedef struct packed {
    logic        big_endian;
    logic        cpu_enable;
    logic        bus_user_flag;
    logic [1:0]  boot_chip_select_config;
    logic [10:0] system_id_strap;
  } boot_config_t;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [31:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

// File: hw/reset_stretch.sv
/*
  Reset stretcher: holds its output high for a programmable count after a trigger pulse.
  Assumes trigger is a one-cycle pulse synchronous to clk.
*/
`timescale 1ns/100ps
module reset_stretch
  import clk_rst_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       trigger,
  input  wire logic [4:0] length,
  output      logic       active
);

  logic [4:0] count;
  logic [4:0] next_count;

  assign next_count = trigger ? length : ((count != 5'h00) ? count - 5'h01 : 5'h00);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count  <= 5'h00;
      active <= 1'b0;
    end else begin
      count  <= next_count;
      active <= (next_count != 5'h00);
    end
  end

endmodule // reset_stretch

// File: hw/clk_rst_ctrl.sv
/*
  Clock, reset and bootstrap control: strap latching, PLL rate select, reset merge.
  Assumes straps are stable while reset_n_pin is low and the register port is synchronous to clk.
*/
// Functional notes
// (RULE_01) rate select field bits 27:24, reset 9
// (RULE_02) power-up PLL setting only from straps
// (RULE_03) changing rate select resets the chip
// (RULE_04) readback invalid until first write
// (RULE_05) rate write keeps strapped output divider
// (RULE_06) multiplier plus one equals select plus five
// (RULE_07) charge pump from select ranges
// (RULE_08) pin, watchdog and software reset sources
// (RULE_09) board holds pin low long enough
// (RULE_10) watchdog reset fires on release edge
// (RULE_11) 123 then 321 triggers software reset
// (RULE_12) software reset keeps configuration registers
// (RULE_13) software reset lasts 16 clocks
// (RULE_14) straps sampled while pin asserted
// (RULE_15) line 27 selects byte order
// (RULE_16) line 26 sets CPU boot and flag
// (RULE_17) lines 24:23 set boot chip select
// (RULE_18) lines 19:9 load system identifier
// (RULE_19) lines 8:0 load PLL settings
// (RULE_20) board pulls down multiplier straps
// (RULE_21) straps default high through pullups
// (RULE_22) new rate survives self reset
`timescale 1ns/100ps
module clk_rst_ctrl
  import clk_rst_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          reset_n_pin,
  input  wire logic          watchdog_reset,
  input  wire logic [27:0]   strap_addr,
  input  wire logic [31:0]   reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_write,
  input  wire logic          reg_read,
  output      logic [31:0]   reg_rdata,
  output      pll_settings_t pll_settings,
  output      boot_config_t  boot_config,
  output      logic          chip_reset,
  output      logic          sw_reset_active
);

  reg_req_t      req;
  pll_settings_t strap_pll;
  pll_settings_t next_pll_settings;
  boot_config_t  next_boot_config;
  logic [3:0]    rate_select;
  logic          rate_written;
  logic          key_armed;
  logic          watchdog_prev;
  logic          pin_prev;
  logic          sw_hold;
  logic          rate_hold;

  assign req = '{write: reg_write, read: reg_read, addr: reg_addr, wdata: reg_wdata};

  // decode
  wire        hit_rate     = req.addr == pll_rate_control_addr;
  wire        hit_service  = req.addr == sw_service_addr;
  wire        hit_settings = req.addr == pll_settings_addr;
  wire        hit_boot     = req.addr == boot_status_addr;
  wire [3:0]  new_select   = req.wdata[rate_sel_msb:rate_sel_lsb];
  wire        rate_wr      = req.write && hit_rate;
  wire        rate_change  = rate_wr && (new_select != rate_select); // see (RULE_03)
  wire        service_wr   = req.write && hit_service;
  wire [11:0] service_key  = req.wdata[11:0];
  wire        sw_trigger   = service_wr && key_armed && (service_key == sw_key_second); // see (RULE_11)
  wire        wd_trigger   = watchdog_prev && !watchdog_reset; // see (RULE_10)
  wire        pin_low      = !reset_n_pin; // see (RULE_08)

  // multiplier and charge pump from the select value
  wire [4:0]  sel_mult     = {1'b0, new_select} + rate_sel_mult_offset; // see (RULE_06)
  wire [1:0]  sel_cp       = (new_select <= cp_low_last) ? cp_low :
                             (new_select <= cp_mid_last) ? cp_mid : cp_high; // see (RULE_07)

  // straps: unfitted lines read high via on-die pullups, so board only pulls down
  always_comb begin
    strap_pll.charge_pump_current = strap_addr[strap_cp_lsb +: 2];   // see (RULE_19) (RULE_21)
    strap_pll.pll_output_divider  = strap_addr[strap_div_lsb +: 2];  // see (RULE_19)
    strap_pll.pll_multiplier      = strap_addr[strap_mult_lsb +: 5]; // see (RULE_19) (RULE_20)
  end

  always_comb begin
    next_boot_config = boot_config;
    next_pll_settings = pll_settings;
    if (pin_low) begin // see (RULE_14) (RULE_02)
      next_boot_config.big_endian              = strap_addr[strap_endian_bit];   // see (RULE_15)
      next_boot_config.cpu_enable              = strap_addr[strap_cpu_boot_bit]; // see (RULE_16)
      next_boot_config.bus_user_flag           = !strap_addr[strap_cpu_boot_bit];
      next_boot_config.boot_chip_select_config = strap_addr[strap_cs_lsb +: 2];  // see (RULE_17)
      next_boot_config.system_id_strap         = strap_addr[strap_id_lsb +: 11]; // see (RULE_18)
      next_pll_settings                        = strap_pll;
    end else if (rate_wr) begin
      next_pll_settings.charge_pump_current = sel_cp;   // see (RULE_07)
      next_pll_settings.pll_multiplier      = sel_mult; // see (RULE_06) (RULE_05)
    end
  end

  // configuration registers are cleared by the asynchronous reset and reloaded while reset_n_pin is low,
  // never by software, watchdog or rate-change resets
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      boot_config  <= '0;
      pll_settings <= '0;
      rate_select  <= rate_sel_reset; // see (RULE_01)
      rate_written <= 1'b0;
    end else begin
      boot_config  <= next_boot_config; // see (RULE_12)
      pll_settings <= next_pll_settings; // see (RULE_22)
      if (pin_low) begin
        rate_select  <= rate_sel_reset;
        rate_written <= 1'b0;
      end else if (rate_wr) begin
        rate_select  <= new_select; // see (RULE_01) (RULE_22)
        rate_written <= 1'b1; // see (RULE_04)
      end
    end
  end

  // software service key sequence
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      key_armed     <= 1'b0;
      watchdog_prev <= 1'b0;
      pin_prev      <= 1'b0;
    end else begin
      watchdog_prev <= watchdog_reset;
      pin_prev      <= pin_low;
      if (service_wr) begin
        key_armed <= (service_key == sw_key_first); // see (RULE_11)
      end
    end
  end

  reset_stretch u_sw_stretch (
    .clk     (clk),
    .reset   (reset),
    .trigger (sw_trigger),
    .length  (sw_reset_cycles),
    .active  (sw_hold)
  ); // see (RULE_13)

  reset_stretch u_rate_stretch (
    .clk     (clk),
    .reset   (reset),
    .trigger (rate_change | wd_trigger),
    .length  (rate_reset_cycles),
    .active  (rate_hold)
  ); // see (RULE_03) (RULE_10)

  // read mux; rate readback reads zero until first write
  wire [31:0] rd_rate     = rate_written ? {4'h0, rate_select, 24'h00_0000} : 32'h0000_0000; // see (RULE_04)
  wire [31:0] rd_settings = {23'h00_0000, pll_settings};
  wire [31:0] rd_boot     = {14'h0000, boot_config.big_endian, boot_config.cpu_enable,
                             boot_config.bus_user_flag, 2'h0, boot_config.boot_chip_select_config,
                             boot_config.system_id_strap};
  wire [31:0] rd_value    = hit_rate ? rd_rate : hit_settings ? rd_settings :
                            hit_boot ? rd_boot : 32'h0000_0000;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata       <= 32'h0000_0000;
      chip_reset      <= 1'b1;
      sw_reset_active <= 1'b0;
    end else begin
      reg_rdata       <= req.read ? rd_value : 32'h0000_0000;
      chip_reset      <= pin_low | pin_prev | sw_hold | rate_hold; // see (RULE_08)
      sw_reset_active <= sw_hold;
    end
  end

endmodule // clk_rst_ctrl

// File: test/clk_rst_ctrl_checker.sv
/* port checker for clk_rst_ctrl
   assumes clk_rst_pkg is compiled first and the bind below finds the design */
`timescale 1ns/100ps
module clk_rst_ctrl_checker
  import clk_rst_pkg::*;
(
  input wire logic clk, reset, reset_n_pin, watchdog_reset, reg_write, reg_read, chip_reset, sw_reset_active,
  input wire logic [27:0] strap_addr,
  input wire logic [31:0] reg_addr, reg_wdata, reg_rdata,
  input wire pll_settings_t pll_settings,
  input wire boot_config_t boot_config
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [4:0]  run;
  logic [3:0]  last_sel;
  logic [27:0] strap_d;
  wire         rate_wr = reg_write && reg_addr == pll_rate_control_addr && reset_n_pin;
  wire [3:0]   sel     = reg_wdata[27:24];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run <= 5'h00;
      last_sel <= rate_sel_reset;
      strap_d <= 28'h000_0000;
    end else begin
      run <= sw_reset_active ? run + 5'h01 : 5'h00;
      last_sel <= !reset_n_pin ? rate_sel_reset : rate_wr ? sel : last_sel;
      strap_d <= strap_addr;
    end
  end
  sequence s_key1; reg_write && reg_addr == sw_service_addr && reg_wdata[11:0] == sw_key_first; endsequence
  sequence s_key2; reg_write && reg_addr == sw_service_addr && reg_wdata[11:0] == sw_key_second; endsequence
  property p_mult; rate_wr |=> pll_settings.pll_multiplier == $past(sel) + rate_sel_mult_offset; endproperty
  property p_cp; rate_wr |=> pll_settings.charge_pump_current ==
    ($past(sel) <= 4'h2 ? 2'h1 : $past(sel) <= 4'ha ? 2'h2 : 2'h3); endproperty
  property p_div; rate_wr |=> $stable(pll_settings.pll_output_divider); endproperty
  property p_rate_rst; rate_wr && sel != last_sel |-> ##2 chip_reset [*8]; endproperty
  property p_sw_trig; s_key1 ##1 s_key2 |-> ##2 sw_reset_active && chip_reset; endproperty
  property p_sw_len; $fell(sw_reset_active) |-> run == sw_reset_cycles; endproperty
  property p_wd; $fell(watchdog_reset) |-> ##[1:3] chip_reset; endproperty
  property p_pin; !reset_n_pin |=> chip_reset; endproperty
  property p_strap; !reset_n_pin |=> pll_settings == strap_d[8:0] &&
    boot_config == {strap_d[27:26], !strap_d[26], strap_d[24:23], strap_d[19:9]}; endproperty
  a_mult: assert property (p_mult) else $error("multiplier wrong");
  a_cp: assert property (p_cp) else $error("charge pump wrong");
  a_div: assert property (p_div) else $error("divider moved");
  a_rate_rst: assert property (p_rate_rst) else $error("no rate reset");
  a_sw_trig: assert property (p_sw_trig) else $error("no soft reset");
  a_sw_len: assert property (p_sw_len) else $error("soft reset length");
  a_wd: assert property (p_wd) else $error("no watchdog reset");
  a_pin: assert property (p_pin) else $error("no pin reset");
  a_strap: assert property (p_strap) else $error("strap latch wrong");
endmodule // clk_rst_ctrl_checker
bind clk_rst_ctrl clk_rst_ctrl_checker u_chk(.clk(clk), .reset(reset), .reset_n_pin(reset_n_pin),
  .watchdog_reset(watchdog_reset), .reg_write(reg_write), .reg_read(reg_read), .chip_reset(chip_reset),
  .sw_reset_active(sw_reset_active), .strap_addr(strap_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .pll_settings(pll_settings), .boot_config(boot_config));

// File: test/clk_rst_ctrl_bench.sv
/* self-checking bench for clk_rst_ctrl
   assumes clk_rst_pkg and the design are compiled first */
`timescale 1ns/100ps
`define chk(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module clk_rst_ctrl_bench import clk_rst_pkg::*; ;
  logic          clk = 0, reset = 1, reset_n_pin = 1, watchdog_reset = 0, reg_write = 0, reg_read = 0, rd_d = 0;
  logic [27:0]   s;
  logic [31:0]   reg_addr = 0, reg_wdata = 0, reg_rdata, exp, seed = 32'h3969;
  pll_settings_t pll_settings;
  boot_config_t  boot_config;
  logic          chip_reset, sw_reset_active;
  logic [31:0]   q[$];
  int            errors = 0, cmp_count = 0, n;
  always #5 clk = ~clk;
  clk_rst_ctrl u_dut(.clk(clk), .reset(reset), .reset_n_pin(reset_n_pin), .watchdog_reset(watchdog_reset),
    .strap_addr(s), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .pll_settings(pll_settings), .boot_config(boot_config), .chip_reset(chip_reset),
    .sw_reset_active(sw_reset_active));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [1:0] cp(input logic [3:0] v);
    return v <= 4'h2 ? 2'h1 : v <= 4'ha ? 2'h2 : 2'h3;
  endfunction
  task automatic wr(input logic [31:0] a, d);
    reg_write <= 1;
    reg_read <= 0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a, e);
    reg_read <= 1;
    reg_write <= 0;
    reg_addr <= a;
    q.push_back(e);
    @(posedge clk);
  endtask
  task automatic idle(input int c);
    reg_read <= 0;
    reg_write <= 0;
    repeat (c) @(posedge clk);
  endtask
  // waits out any self reset, bounded
  task automatic settle;
    n = 0;
    idle(3);
    while (chip_reset !== 1'b0 && n < 60) begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    rd_d <= reg_read;
    if (rd_d) begin
      exp = q.pop_front();
      `chk("reg_rdata", exp, reg_rdata)
    end
  end
  task end_of_test;
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    end_of_test;
  end
  initial begin
    seed = lfsr(lfsr(seed));
    s = seed[27:0];
    repeat (5) @(posedge clk);
    reset <= 0;
    reset_n_pin <= 0;
    repeat (4) @(posedge clk);
    reset_n_pin <= 1;
    settle;
    rd(boot_status_addr, {14'h0, s[27:26], !s[26], 2'b00, s[24:23], s[19:9]});
    rd(pll_settings_addr, {23'h0, s[8:0]});
    rd(pll_rate_control_addr, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      wr(pll_rate_control_addr, {4'h0, i[3:0], 24'h0});
      settle;
      rd(pll_settings_addr, {23'h0, cp(i[3:0]), s[6:5], i[4:0] + 5'h04});
      rd(pll_rate_control_addr, {4'h0, i[3:0], 24'h0});
    end
    wr(sw_service_addr, 32'h0000_0123);
    wr(sw_service_addr, 32'h0000_0321);
    idle(1);
    n = 0;
    repeat (30) @(negedge clk) n += sw_reset_active;
    `chk("sw_reset_len", 16, n)
    @(posedge clk);
    rd(pll_settings_addr, {23'h0, 2'h3, s[6:5], 5'h13});
    rd(32'hffb0_0100, 32'h0000_0000);
    watchdog_reset <= 1;
    idle(3);
    watchdog_reset <= 0;
    n = 0;
    repeat (20) @(negedge clk) n += chip_reset;
    `chk("wd_reset", 16, n)
    @(posedge clk);
    idle(2);
    end_of_test;
  end
endmodule // clk_rst_ctrl_bench
